// file: rtl/cgmcfg_regs.svh
// Named constants of the clock generator control block.
// Assumes inclusion by bare name from rtl/ before the package.
`ifndef CGMCFG_REGS_SVH
`define CGMCFG_REGS_SVH

`define CGMCFG_MULT_W 12
`define CGMCFG_RANGE_W 8
`define CGMCFG_MULT_RST 12'h040
`define CGMCFG_RANGE_RST 8'h40
`define CGMCFG_RANGE_PWR_RST 2'h0
`define CGMCFG_LOOP_ON_RST 1'h1
`define CGMCFG_SELECT_RST 1'h0
`define CGMCFG_MULT_ONE 12'h001
`define CGMCFG_MULT_ZERO 12'h000
`define CGMCFG_RANGE_ZERO 8'h00
`define CGMCFG_SW_EDGES 2'h3
`define CGMCFG_SRC_XTAL 1'h0
`define CGMCFG_SRC_VCO 1'h1

`endif

// file: rtl/cgmcfg_pkg.sv
// Types shared by the clock generator control block.
// Assumes cgmcfg_regs.svh is on the include path.
`include "cgmcfg_regs.svh"

package cgmcfg_pkg;

  typedef struct packed {
    logic loop_power_on;
    logic base_source_select;
    logic [1:0] range_power_bits;
  } cgmcfg_ctrl_t;

  typedef enum logic [1:0] {
    CGMCFG_RUN,
    CGMCFG_OLD_WAIT,
    CGMCFG_NEW_WAIT
  } cgmcfg_sw_t;

  typedef struct packed {
    cgmcfg_ctrl_t ctrl;
    logic [`CGMCFG_MULT_W-1:0] mult;
    logic [`CGMCFG_RANGE_W-1:0] range;
    logic xtal_prev;
    logic vco_prev;
    logic active_src;
    cgmcfg_sw_t sw;
    logic [1:0] sw_cnt;
    logic base;
    logic bus;
    logic [`CGMCFG_MULT_W-1:0] fb_cnt;
    logic fb_pulse;
    logic loop_en;
    logic osc_en;
    logic busy;
  } cgmcfg_state_t;

endpackage

// file: rtl/cgmcfg_top.sv
// Digital control of the clock generator: multiplier programming, source
// switch with hold, divide by two and feedback divider.
// Assumes both source clocks are slow against clk_sys and synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "cgmcfg_regs.svh"

module cgmcfg_top (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic crystal_clock, // Crystal oscillator clock.
  input wire logic vco_clock, // VCO clock.
  input wire logic osc_enable_from_integration, // Oscillator and loop enable.
  input wire logic ctrl_wr, // Control register write strobe.
  input wire cgmcfg_pkg::cgmcfg_ctrl_t ctrl_wdata, // Control write data.
  input wire logic mult_wr, // Multiplier write strobe.
  input wire logic [`CGMCFG_MULT_W-1:0] mult_wdata, // Multiplier N.
  input wire logic range_wr, // Linear range write strobe.
  input wire logic [`CGMCFG_RANGE_W-1:0] range_wdata, // Linear range L.
  output logic [3:0] ctrl_rdata, // Control register contents.
  output logic [`CGMCFG_MULT_W-1:0] mult_rdata, // Multiplier contents.
  output logic [`CGMCFG_RANGE_W-1:0] range_rdata, // Linear range contents.
  output logic base_clock_out, // Base clock, source over two.
  output logic bus_clock, // Bus clock, source over four.
  output logic source_is_vco, // Active base clock source.
  output logic switch_busy, // Source transition in progress.
  output logic vco_feedback, // One pulse per N VCO edges.
  output logic loop_enable, // Analog loop enable.
  output logic osc_enable // Crystal oscillator enable.
);

  cgmcfg_pkg::cgmcfg_state_t state_q;
  cgmcfg_pkg::cgmcfg_state_t state_d;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  function automatic logic [`CGMCFG_MULT_W-1:0] n_eff(
      input logic [`CGMCFG_MULT_W-1:0] n);
    n_eff = (n == `CGMCFG_MULT_ZERO) ? `CGMCFG_MULT_ONE : n;
  endfunction

  logic xtal_edge;
  logic vco_edge;
  logic range_zero;
  logic old_edge;
  logic new_edge;
  logic sel_edge;

  assign xtal_edge = rise(crystal_clock, state_q.xtal_prev);
  assign vco_edge = rise(vco_clock, state_q.vco_prev);
  assign range_zero = state_q.range == `CGMCFG_RANGE_ZERO;
  assign old_edge = state_q.active_src ? vco_edge : xtal_edge;
  assign new_edge = state_q.active_src ? xtal_edge : vco_edge;
  assign sel_edge = old_edge;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    state_d.xtal_prev = crystal_clock;
    state_d.vco_prev = vco_clock;
    state_d.osc_en = osc_enable_from_integration;
    state_d.fb_pulse = 1'b0;
    if (ctrl_wr) begin
      if (!state_q.ctrl.loop_power_on) begin
        state_d.ctrl.range_power_bits = ctrl_wdata.range_power_bits;
      end
      state_d.ctrl.loop_power_on = ctrl_wdata.loop_power_on |
        state_q.ctrl.base_source_select;
      state_d.ctrl.base_source_select = ctrl_wdata.base_source_select &
        state_q.ctrl.loop_power_on & ~range_zero;
    end
    if (!state_q.ctrl.loop_power_on || range_zero) begin
      state_d.ctrl.base_source_select = 1'b0;
    end
    if (!state_q.ctrl.loop_power_on) begin
      if (mult_wr) begin
        state_d.mult = mult_wdata;
      end
      if (range_wr) begin
        state_d.range = range_wdata;
      end
    end
    state_d.loop_en = state_q.osc_en & state_q.ctrl.loop_power_on &
      ~range_zero;
    // Feedback divider counts VCO edges while the loop runs.
    if (!state_q.loop_en) begin
      state_d.fb_cnt = `CGMCFG_MULT_ZERO;
    end else if (vco_edge) begin
      if (state_q.fb_cnt >= n_eff(state_q.mult) - `CGMCFG_MULT_ONE) begin
        state_d.fb_cnt = `CGMCFG_MULT_ZERO;
        state_d.fb_pulse = 1'b1;
      end else begin
        state_d.fb_cnt = state_q.fb_cnt + `CGMCFG_MULT_ONE;
      end
    end
    // Source switch: finish three edges of the old source, then three of
    // the new one, holding the base clock throughout.
    case (state_q.sw)
      cgmcfg_pkg::CGMCFG_RUN: begin
        if (state_q.active_src != state_q.ctrl.base_source_select) begin
          state_d.sw = cgmcfg_pkg::CGMCFG_OLD_WAIT;
          state_d.sw_cnt = 2'h0;
        end else if (sel_edge) begin
          state_d.base = ~state_q.base;
          if (!state_q.base) begin
            state_d.bus = ~state_q.bus;
          end
        end
      end
      cgmcfg_pkg::CGMCFG_OLD_WAIT: begin
        if (old_edge) begin
          state_d.sw_cnt = state_q.sw_cnt + 2'h1;
          if (state_q.sw_cnt == `CGMCFG_SW_EDGES - 2'h1) begin
            state_d.sw = cgmcfg_pkg::CGMCFG_NEW_WAIT;
            state_d.sw_cnt = 2'h0;
          end
        end
      end
      cgmcfg_pkg::CGMCFG_NEW_WAIT: begin
        if (new_edge) begin
          state_d.sw_cnt = state_q.sw_cnt + 2'h1;
          if (state_q.sw_cnt == `CGMCFG_SW_EDGES - 2'h1) begin
            state_d.sw = cgmcfg_pkg::CGMCFG_RUN;
            state_d.active_src = ~state_q.active_src;
            state_d.sw_cnt = 2'h0;
          end
        end
      end
      default: begin
        state_d.sw = cgmcfg_pkg::CGMCFG_RUN;
      end
    endcase
    // Busy is registered so that the output comes straight from a flop.
    state_d.busy = state_d.sw != cgmcfg_pkg::CGMCFG_RUN;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '0;
      state_q.ctrl.loop_power_on <= `CGMCFG_LOOP_ON_RST;
      state_q.ctrl.base_source_select <= `CGMCFG_SELECT_RST;
      state_q.ctrl.range_power_bits <= `CGMCFG_RANGE_PWR_RST;
      state_q.mult <= `CGMCFG_MULT_RST;
      state_q.range <= `CGMCFG_RANGE_RST;
      state_q.active_src <= `CGMCFG_SRC_XTAL;
      state_q.sw <= cgmcfg_pkg::CGMCFG_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign ctrl_rdata = state_q.ctrl;
  assign mult_rdata = state_q.mult;
  assign range_rdata = state_q.range;
  assign base_clock_out = state_q.base;
  assign bus_clock = state_q.bus;
  assign source_is_vco = state_q.active_src;
  assign switch_busy = state_q.busy;
  assign vco_feedback = state_q.fb_pulse;
  assign loop_enable = state_q.loop_en;
  assign osc_enable = state_q.osc_en;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_old_done;
    state_q.sw == cgmcfg_pkg::CGMCFG_OLD_WAIT ##1
      state_q.sw == cgmcfg_pkg::CGMCFG_NEW_WAIT;
  endsequence

  chk_select_refused: assert property (
    ctrl_wr && !state_q.ctrl.loop_power_on |=> !state_q.ctrl.base_source_select)
    else $error("VCO selected while loop off");
  chk_loop_on_kept: assert property (
    ctrl_wr && state_q.ctrl.base_source_select |=> state_q.ctrl.loop_power_on)
    else $error("Loop powered off while VCO selected");
  chk_range_zero: assert property (
    range_zero |=> !state_q.ctrl.base_source_select && !state_q.loop_en)
    else $error("Zero range did not force crystal");
  chk_range_pwr_locked: assert property (
    state_q.ctrl.loop_power_on |=> $stable(state_q.ctrl.range_power_bits))
    else $error("Range power bits changed while loop on");
  chk_prog_locked: assert property (
    state_q.ctrl.loop_power_on |=> $stable(state_q.mult) &&
      $stable(state_q.range))
    else $error("Programming changed while loop on");
  chk_hold_static: assert property (
    switch_busy |=> $stable(state_q.base))
    else $error("Base clock moved during switch");
  chk_bus_quarter: assert property (
    $changed(state_q.bus) |-> $rose(state_q.base))
    else $error("Bus clock not on base rising edge");
  chk_zero_mult: assert property (
    state_q.loop_en && state_q.mult == `CGMCFG_MULT_ZERO && vco_edge
      |=> state_q.fb_pulse)
    else $error("Zero multiplier not treated as one");
  chk_switch_order: assert property (
    s_old_done |-> state_q.sw_cnt == 2'h0 && $past(old_edge) &&
      $past(state_q.sw_cnt) == `CGMCFG_SW_EDGES - 2'h1)
    else $error("Switch left old source badly");
  chk_reset_values: assert property (
    $fell(reset) |-> state_q.ctrl.loop_power_on &&
      !state_q.ctrl.base_source_select)
    else $error("Wrong control values after reset");

endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the clock generator control block.
// Assumes the design package and cgmcfg_top are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {string nm; int sel; logic [11:0] exp; logic [11:0] val;}
    cgmcfg_note_t;
  logic clk_sys = 0, reset = 1, xt = 0, vc = 0, osc_in = 0;
  logic ctrl_wr = 0, mult_wr = 0, range_wr = 0;
  cgmcfg_pkg::cgmcfg_ctrl_t ctrl_wdata = '0;
  logic [11:0] mult_wdata = 12'h000;
  logic [7:0] range_wdata = 8'h00;
  logic [3:0] ctrl_rdata;
  logic [11:0] mult_rdata;
  logic [7:0] range_rdata;
  logic base, bus, src, busy, fb, loop_en, osc_en;
  int fails = 0, n_compared = 0, cx = 0, cv = 0;
  logic [31:0] rnd = 32'hCE12;
  logic [1:0] v;
  logic [11:0] n;
  cgmcfg_note_t q[$];
  cgmcfg_top cgmcfg_top_inst (.clk_sys(clk_sys), .reset(reset),
    .crystal_clock(xt), .vco_clock(vc), .osc_enable_from_integration(osc_in),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .mult_wr(mult_wr),
    .mult_wdata(mult_wdata), .range_wr(range_wr), .range_wdata(range_wdata),
    .ctrl_rdata(ctrl_rdata), .mult_rdata(mult_rdata),
    .range_rdata(range_rdata), .base_clock_out(base), .bus_clock(bus),
    .source_is_vco(src), .switch_busy(busy), .vco_feedback(fb),
    .loop_enable(loop_en), .osc_enable(osc_en));
  always #50 clk_sys = ~clk_sys;
  // Crystal has a period of 6 system cycles, the VCO one of 4.
  always @(posedge clk_sys) begin
    cx <= (cx == 2) ? 0 : cx + 1;
    cv <= (cv == 1) ? 0 : cv + 1;
    if (cx == 2) xt <= ~xt;
    if (cv == 1) vc <= ~vc;
  end
  // ==========================================================
  // Checking
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string nm, logic [11:0] got, logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  always @(negedge clk_sys) begin
    while (q.size() > 0) begin
      cgmcfg_note_t e;
      e = q.pop_front();
      case (e.sel)
        0: check(e.nm, {8'h00, ctrl_rdata}, e.exp);
        1: check(e.nm, mult_rdata, e.exp);
        2: check(e.nm, {4'h0, range_rdata}, e.exp);
        3: check(e.nm, {11'h000, src}, e.exp);
        4: check(e.nm, {11'h000, loop_en}, e.exp);
        5: check(e.nm, {11'h000, osc_en}, e.exp);
        default: check(e.nm, e.val, e.exp);
      endcase
    end
  end
  task automatic note(string nm, int sel, logic [11:0] exp, logic [11:0] val);
    q.push_back('{nm, sel, exp, val});
    @(negedge clk_sys);
  endtask
  // ==========================================================
  // Stimulus
  task automatic wr(input int k, input logic [11:0] d);
    @(posedge clk_sys);
    if (k == 0) begin ctrl_wr <= 1; ctrl_wdata <= d[3:0]; end
    if (k == 1) begin mult_wr <= 1; mult_wdata <= d; end
    if (k == 2) begin range_wr <= 1; range_wdata <= d[7:0]; end
    @(posedge clk_sys);
    ctrl_wr <= 0;
    mult_wr <= 0;
    range_wr <= 0;
  endtask
  task automatic sw(input logic e);
    int k, chg;
    logic b0;
    k = 0;
    chg = 0;
    while (busy !== 1'b1 && k < 60) begin @(negedge clk_sys); k++; end
    b0 = base;
    while (busy === 1'b1 && k < 120) begin
      @(negedge clk_sys);
      k++;
      if (base !== b0) chg++;
    end
    note("base_hold", 9, 12'h000, chg[11:0]);
    note("source", 3, {11'h000, e}, 12'h000);
  endtask
  function automatic logic [11:0] near(int got, int exp);
    return {11'h000, (got >= exp - 1) && (got <= exp + 1)};
  endfunction
  task automatic meas(input int p, input int efb);
    int b, u, f;
    logic pb, pu;
    b = 0; u = 0; f = 0; pb = base; pu = bus;
    repeat (480) begin
      @(negedge clk_sys);
      if (base && !pb) b++;
      if (bus && !pu) u++;
      if (fb === 1'b1) f++;
      pb = base;
      pu = bus;
    end
    note("base_rate", 9, 12'h001, near(b, 240 / p));
    note("bus_rate", 9, 12'h001, near(u, 120 / p));
    note("fb_rate", 9, 12'h001, near(f, efb));
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    note("ctrl_rst", 0, 12'h008, 0);
    note("mult_rst", 1, 12'h040, 0);
    note("range_rst", 2, 12'h040, 0);
    note("src_rst", 3, 12'h000, 0);
    note("loop_off", 4, 12'h000, 0);
    note("osc_off", 5, 12'h000, 0);
    @(posedge clk_sys) osc_in <= 1;
    repeat (3) @(posedge clk_sys);
    note("loop_on", 4, 12'h001, 0);
    note("osc_on", 5, 12'h001, 0);
    rnd = lfsr(rnd);
    v = 2'(rnd[7:0] % 3);
    n = 12'(2 + rnd[15:8] % 8);
    wr(0, 12'h00A); note("vpr_lock", 0, 12'h008, 0);
    wr(1, 12'h123); note("mult_lock", 1, 12'h040, 0);
    wr(2, 12'h055); note("range_lock", 2, 12'h040, 0);
    wr(0, {10'h0, v}); note("off", 0, 12'h000, 0);
    wr(0, {10'h1, v}); note("sel_off", 0, {10'h0, v}, 0);
    wr(1, 12'h000); note("mult_wr", 1, 12'h000, 0);
    wr(0, {10'h3, v}); note("on_sel", 0, {10'h2, v}, 0);
    wr(0, {10'h3, v}); note("sel_on", 0, {10'h3, v}, 0);
    sw(1'b1);
    meas(4, 120);
    wr(0, {10'h1, v}); note("off_sel", 0, {10'h3, v}, 0);
    wr(0, {10'h0, v}); note("desel_off", 0, {10'h2, v}, 0);
    sw(1'b0);
    wr(0, {10'h0, v});
    wr(1, n);
    wr(2, 12'h000);
    wr(0, {10'h2, v});
    wr(0, {10'h3, v}); note("sel_l0", 0, {10'h2, v}, 0);
    note("loop_l0", 4, 12'h000, 0);
    note("src_l0", 3, 12'h000, 0);
    wr(0, {10'h0, v});
    wr(2, {4'h0, rnd[23:16] | 8'h01});
    wr(0, {10'h2, v});
    meas(6, 120 / int'(n));
    end_of_test();
  end
endmodule
`default_nettype wire
